/* logic/vscc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module vscc_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire vscc_pkg::vscc_cfg_t cfg_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic clamp_in,
  input wire logic coast_in,
  input wire logic green_embedded_sync_in,
  input wire logic pix_valid,
  input wire vscc_pkg::vscc_pix_t pix_in,
  output logic [5:0] sog_threshold,
  output logic pll_ref_pulse,
  output logic pll_track,
  output logic clamp_active,
  output logic green_slicer_out,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic pixel_data_strobe,
  output var vscc_pkg::vscc_pix_t pix_out
);

  vscc_pkg::vscc_cfg_t cfg_q;
  logic [5:0] sog_sat;
  logic [vscc_pkg::SYNC_N-1:0] raw;
  logic [vscc_pkg::SYNC_N-1:0] s1_q;
  logic [vscc_pkg::SYNC_N-1:0] s2_q;
  logic hs_s;
  logic vs_s;
  logic clamp_s;
  logic coast_s;
  logic green_s;
  logic hs_act;
  logic hs_act_q;
  logic hs_lead;
  logic hs_trail;
  logic coast_act;
  logic clamp_ext_act;
  vscc_pkg::vscc_clamp_st_t clamp_st_q;
  logic [7:0] clamp_cnt_q;
  logic [7:0] hso_cnt_q;
  logic hso_act;
  vscc_pkg::vscc_grp_t grp_in;
  vscc_pkg::vscc_grp_t grp_out;
  logic pll_ref_pulse_q;
  logic pll_track_q;
  logic clamp_active_q;
  logic green_slicer_out_q;
  logic line_sync_out_q;
  logic frame_sync_out_q;
  logic pixel_data_strobe_q;
  vscc_pkg::vscc_pix_t pix_out_q;
  logic [8:0] since_trail_q;

  // Settings arrive from the serial port decoder as one word.
  always_comb begin
    if (cfg_in.sog_level < vscc_pkg::SOG_MIN) begin
      sog_sat = vscc_pkg::SOG_MIN;
    end else if (cfg_in.sog_level > vscc_pkg::SOG_MAX) begin
      sog_sat = vscc_pkg::SOG_MAX;
    end else begin
      sog_sat = cfg_in.sog_level;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= vscc_pkg::CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= cfg_in;
      cfg_q.sog_level <= sog_sat;
    end
  end

  assign sog_threshold = cfg_q.sog_level;

  // Two-stage synchronisers; only the second stage is used downstream.
  assign raw[vscc_pkg::SI_HS] = hsync_in;
  assign raw[vscc_pkg::SI_VS] = vsync_in;
  assign raw[vscc_pkg::SI_CLAMP] = clamp_in;
  assign raw[vscc_pkg::SI_COAST] = coast_in;
  assign raw[vscc_pkg::SI_GREEN] = green_embedded_sync_in;

  for (genvar i = 0; i < vscc_pkg::SYNC_N; i++) begin : g_sync
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  assign hs_s = s2_q[vscc_pkg::SI_HS];
  assign vs_s = s2_q[vscc_pkg::SI_VS];
  assign clamp_s = s2_q[vscc_pkg::SI_CLAMP];
  assign coast_s = s2_q[vscc_pkg::SI_COAST];
  assign green_s = s2_q[vscc_pkg::SI_GREEN];

  // Polarity bit at one means the pin is active high.
  assign hs_act = ~(hs_s ^ cfg_q.hs_pol);
  assign coast_act = ~(coast_s ^ cfg_q.coast_pol);
  assign clamp_ext_act = ~(clamp_s ^ cfg_q.clamp_pol);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // Matches hs_act just after reset, so no false leading edge follows it.
      hs_act_q <= 1'b1;
    end else begin
      hs_act_q <= hs_act;
    end
  end

  assign hs_lead = hs_act & ~hs_act_q;
  assign hs_trail = ~hs_act & hs_act_q;

  // Reference pulses feed the clock generator; freewheel gates them off.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pll_ref_pulse_q <= 1'b0;
      pll_track_q <= 1'b0;
    end else begin
      pll_ref_pulse_q <= hs_lead & ~coast_act;
      pll_track_q <= ~coast_act;
    end
  end

  assign pll_ref_pulse = pll_ref_pulse_q;
  assign pll_track = pll_track_q;

  // Internal clamp window: placement count, then duration count.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clamp_st_q <= vscc_pkg::CL_IDLE;
      clamp_cnt_q <= '0;
    end else if (hs_trail && !cfg_q.ext_clamp) begin
      if (cfg_q.clamp_place != '0) begin
        clamp_st_q <= vscc_pkg::CL_PLACE;
        clamp_cnt_q <= cfg_q.clamp_place;
      end else if (cfg_q.clamp_dur != '0) begin
        clamp_st_q <= vscc_pkg::CL_HOLD;
        clamp_cnt_q <= cfg_q.clamp_dur;
      end else begin
        clamp_st_q <= vscc_pkg::CL_IDLE;
      end
    end else begin
      unique case (clamp_st_q)
        vscc_pkg::CL_IDLE: begin
          clamp_cnt_q <= '0;
        end
        vscc_pkg::CL_PLACE: begin
          if (clamp_cnt_q == vscc_pkg::CNT_ONE) begin
            if (cfg_q.clamp_dur != '0) begin
              clamp_st_q <= vscc_pkg::CL_HOLD;
              clamp_cnt_q <= cfg_q.clamp_dur;
            end else begin
              clamp_st_q <= vscc_pkg::CL_IDLE;
            end
          end else begin
            clamp_cnt_q <= clamp_cnt_q - vscc_pkg::CNT_ONE;
          end
        end
        vscc_pkg::CL_HOLD: begin
          if (clamp_cnt_q == vscc_pkg::CNT_ONE) begin
            clamp_st_q <= vscc_pkg::CL_IDLE;
          end
          clamp_cnt_q <= clamp_cnt_q - vscc_pkg::CNT_ONE;
        end
        default: begin
          clamp_st_q <= vscc_pkg::CL_IDLE;
        end
      endcase
    end
  end

  // The pin is ignored unless external clamping is selected.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clamp_active_q <= 1'b0;
    end else if (cfg_q.ext_clamp) begin
      clamp_active_q <= clamp_ext_act;
    end else begin
      clamp_active_q <= (clamp_st_q == vscc_pkg::CL_HOLD);
    end
  end

  assign clamp_active = clamp_active_q;

  // Slicer pin carries the bare comparator or the bare line sync.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      green_slicer_out_q <= 1'b0;
    end else if (cfg_q.sog_sel) begin
      green_slicer_out_q <= hs_s;
    end else begin
      green_slicer_out_q <= green_s;
    end
  end

  assign green_slicer_out = green_slicer_out_q;

  // Regenerated line sync pulse of programmable width.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hso_cnt_q <= '0;
    end else if (hs_lead) begin
      hso_cnt_q <= cfg_q.hso_width;
    end else if (hso_cnt_q != '0) begin
      hso_cnt_q <= hso_cnt_q - vscc_pkg::CNT_ONE;
    end
  end

  assign hso_act = (hso_cnt_q != '0);

  // Sync, strobe and pixels share one delay line so a phase change moves
  // all of them alike.
  always_comb begin
    grp_in.hs = hso_act;
    grp_in.vs = vs_s;
    grp_in.stb = pix_valid;
    grp_in.pix = pix_in;
  end

  vscc_tap_delay u_phase (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(grp_in),
    .tap(cfg_q.phase),
    .out_data(grp_out)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pix_out_q <= '0;
      pixel_data_strobe_q <= 1'b0;
      line_sync_out_q <= 1'b0;
      frame_sync_out_q <= 1'b0;
    end else begin
      pix_out_q <= grp_out.pix;
      pixel_data_strobe_q <= grp_out.stb;
      line_sync_out_q <= ~(grp_out.hs ^ cfg_q.hso_pol);
      frame_sync_out_q <= ~(grp_out.vs ^ cfg_q.vso_pol);
    end
  end

  assign pix_out = pix_out_q;
  assign pixel_data_strobe = pixel_data_strobe_q;
  assign line_sync_out = line_sync_out_q;
  assign frame_sync_out = frame_sync_out_q;

  // Cycles since the last trailing edge, read only by the checks below.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_trail_q <= '0;
    end else if (hs_trail) begin
      since_trail_q <= 9'h001;
    end else if (since_trail_q != vscc_pkg::SINCE_MAX) begin
      since_trail_q <= since_trail_q + 9'h001;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_lead_rise;
    ($rose(hs_s) && cfg_q.hs_pol && $stable(cfg_q.hs_pol) && !coast_act)
      |=> pll_ref_pulse;
  endproperty
  a_lead_rise: assert property (p_lead_rise) else $error("rising lead edge missed");

  property p_trail_ignored;
    ($rose(hs_s) && !cfg_q.hs_pol && $stable(cfg_q.hs_pol)) |=> !pll_ref_pulse;
  endproperty
  a_trail_ignored: assert property (p_trail_ignored) else $error("trailing edge used");

  property p_coast;
    (coast_s == cfg_q.coast_pol) |=> (!pll_track && !pll_ref_pulse);
  endproperty
  a_coast: assert property (p_coast) else $error("tracking during freewheel");

  property p_ext_clamp;
    cfg_q.ext_clamp |=> (clamp_active == $past(clamp_ext_act));
  endproperty
  a_ext_clamp: assert property (p_ext_clamp) else $error("external clamp wrong");

  property p_clamp_place;
    ($rose(clamp_st_q == vscc_pkg::CL_HOLD) && $stable(cfg_q))
      |-> (since_trail_q == {1'b0, cfg_q.clamp_place} + 9'h001);
  endproperty
  a_clamp_place: assert property (p_clamp_place) else $error("clamp start misplaced");

  property p_int_clamp_out;
    (!cfg_q.ext_clamp && $stable(cfg_q.ext_clamp))
      |=> (clamp_active == $past(clamp_st_q == vscc_pkg::CL_HOLD));
  endproperty
  a_int_clamp_out: assert property (p_int_clamp_out) else $error("internal clamp wrong");

  property p_hso_width;
    (hs_lead && cfg_q.hso_width == 8'h04) |=> hso_act[*4];
  endproperty
  a_hso_width: assert property (p_hso_width) else $error("line sync width short");

  property p_phase_align;
    (cfg_q.phase == 5'h05 && $stable(cfg_q.hso_pol))[*8] |->
      (pixel_data_strobe == $past(pix_valid, 8) && pix_out == $past(pix_in, 8)
       && line_sync_out == ~($past(hso_act, 8) ^ cfg_q.hso_pol));
  endproperty
  a_phase_align: assert property (p_phase_align) else $error("outputs misaligned");

  property p_frame_sync;
    (cfg_q.phase == 5'h05 && $stable(cfg_q.vso_pol))[*8] |->
      (frame_sync_out == ~($past(vs_s, 8) ^ cfg_q.vso_pol));
  endproperty
  a_frame_sync: assert property (p_frame_sync) else $error("frame sync wrong");

  property p_slicer;
    !cfg_q.sog_sel |=> (green_slicer_out == $past(green_s));
  endproperty
  a_slicer: assert property (p_slicer) else $error("slicer output altered");

  property p_slicer_hs;
    cfg_q.sog_sel |=> (green_slicer_out == $past(hs_s));
  endproperty
  a_slicer_hs: assert property (p_slicer_hs) else $error("delayed sync wrong");

  property p_sog_range;
    (sog_threshold >= vscc_pkg::SOG_MIN) && (sog_threshold <= vscc_pkg::SOG_MAX);
  endproperty
  a_sog_range: assert property (p_sog_range) else $error("threshold out of range");

endmodule
`default_nettype wire

/* shared/vscc_pkg.sv */
package vscc_pkg;

  // Indices of the synchronised input pins.
  localparam int SYNC_N = 5;
  localparam int SI_HS = 0;
  localparam int SI_VS = 1;
  localparam int SI_CLAMP = 2;
  localparam int SI_COAST = 3;
  localparam int SI_GREEN = 4;

  // Slicer threshold code: the level is code times 10 mV.
  localparam logic [5:0] SOG_MIN = 6'h01;
  localparam logic [5:0] SOG_MAX = 6'h21;
  localparam logic [5:0] SOG_RST = 6'h0f;

  localparam logic [7:0] CLAMP_PLACE_RST = 8'h09;
  localparam logic [7:0] CLAMP_DUR_RST = 8'h14;
  localparam logic [7:0] HSO_WIDTH_RST = 8'h20;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [8:0] SINCE_MAX = 9'h1ff;

  // Sampling phase delay line.
  localparam int PHASE_W = 5;
  localparam int PHASE_DEPTH = 32;

  typedef struct packed {
    logic hs_pol;
    logic sog_sel;
    logic [5:0] sog_level;
    logic ext_clamp;
    logic clamp_pol;
    logic coast_pol;
    logic hso_pol;
    logic [7:0] hso_width;
    logic vso_pol;
    logic [7:0] clamp_place;
    logic [7:0] clamp_dur;
    logic [PHASE_W-1:0] phase;
  } vscc_cfg_t;

  localparam vscc_cfg_t CFG_RST = '{
    hs_pol: 1'b0,
    sog_sel: 1'b0,
    sog_level: SOG_RST,
    ext_clamp: 1'b0,
    clamp_pol: 1'b0,
    coast_pol: 1'b1,
    hso_pol: 1'b1,
    hso_width: HSO_WIDTH_RST,
    vso_pol: 1'b1,
    clamp_place: CLAMP_PLACE_RST,
    clamp_dur: CLAMP_DUR_RST,
    phase: 5'h00
  };

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } vscc_pix_t;

  // Everything that must move together under a phase change.
  typedef struct packed {
    logic hs;
    logic vs;
    logic stb;
    vscc_pix_t pix;
  } vscc_grp_t;

  localparam int GRP_W = $bits(vscc_grp_t);

  typedef enum logic [1:0] {
    CL_IDLE = 2'b00,
    CL_PLACE = 2'b01,
    CL_HOLD = 2'b10
  } vscc_clamp_st_t;

endpackage

/* logic/vscc_tap_delay.sv */
`timescale 1ns/1ps
`default_nettype none
// Shift line with a selectable tap; the tapped word leaves through a register.
module vscc_tap_delay (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [vscc_pkg::GRP_W-1:0] in_data,
  input wire logic [vscc_pkg::PHASE_W-1:0] tap,
  output logic [vscc_pkg::GRP_W-1:0] out_data
);

  logic [vscc_pkg::GRP_W-1:0] mem_q [vscc_pkg::PHASE_DEPTH];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_q[0] <= '0;
    end else begin
      mem_q[0] <= in_data;
    end
  end

  for (genvar i = 1; i < vscc_pkg::PHASE_DEPTH; i++) begin : g_stage
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        mem_q[i] <= '0;
      end else begin
        mem_q[i] <= mem_q[i-1];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_data <= '0;
    end else begin
      out_data <= mem_q[tap];
    end
  end

endmodule
`default_nettype wire

/* testbench/vscc_capture.sv */
`timescale 1ns/1ps
`default_nettype none
// Downstream logic that latches each word on the data strobe, as a scaler input would.
module vscc_capture (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pixel_data_strobe,
  input wire logic line_sync_out,
  input wire vscc_pkg::vscc_pix_t pix_out,
  output var vscc_pkg::vscc_pix_t cap_pix_q,
  output logic cap_hs_q,
  output logic [7:0] cap_cnt_q
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_pix_q <= '0;
      cap_hs_q <= 1'b0;
      cap_cnt_q <= 8'h00;
    end else if (pixel_data_strobe) begin
      cap_pix_q <= pix_out;
      cap_hs_q <= line_sync_out;
      cap_cnt_q <= cap_cnt_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_video_sync_clamp_coast_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_video_sync_clamp_coast_control;
  logic core_clk, rst, cfg_wr, hsync_in, vsync_in, clamp_in, coast_in, green_in, pix_valid;
  vscc_pkg::vscc_cfg_t cfg, cfg_in;
  vscc_pkg::vscc_pix_t pix_in, pix_out, seen, cap_pix;
  logic [5:0] sog_threshold;
  logic pll_ref_pulse, pll_track, clamp_active, green_slicer_out;
  logic line_sync_out, frame_sync_out, pixel_data_strobe, cap_hs;
  logic [7:0] cap_cnt;
  wire logic [6:0] obs;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  // Bit 6 watches the line sync output in its inverted sense.
  assign obs = {~line_sync_out, frame_sync_out, line_sync_out, green_slicer_out,
    clamp_active, pll_ref_pulse, pixel_data_strobe};

  vscc_core DUT (.core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .clamp_in(clamp_in), .coast_in(coast_in),
    .green_embedded_sync_in(green_in), .pix_valid(pix_valid), .pix_in(pix_in),
    .sog_threshold(sog_threshold), .pll_ref_pulse(pll_ref_pulse), .pll_track(pll_track),
    .clamp_active(clamp_active), .green_slicer_out(green_slicer_out),
    .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
    .pixel_data_strobe(pixel_data_strobe), .pix_out(pix_out));
  vscc_capture u_cap (.core_clk(core_clk), .rst(rst), .pixel_data_strobe(pixel_data_strobe),
    .line_sync_out(line_sync_out), .pix_out(pix_out), .cap_pix_q(cap_pix),
    .cap_hs_q(cap_hs), .cap_cnt_q(cap_cnt));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task give_verdict;
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      give_verdict;
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task wr;
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_in <= cfg;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    repeat (40) @(posedge core_clk);
  endtask

  // Counts edges from the stimulus edge to the watched output going high, then its width.
  // A zero delay means the output must stay low for the whole window.
  task meas(input string what, input int idx, input int dly, input int wid);
    int n;
    int w;
    n = 0;
    do begin
      @(posedge core_clk);
      pix_valid <= 1'b0;
      #1;
      n++;
    end while (obs[idx] !== 1'b1 && n < 40);
    seen = pix_out;
    if (dly == 0) chk(what, 32'h0, {31'h0, obs[idx]});
    else chk(what, dly, n);
    if (wid > 0) begin
      w = 0;
      while (obs[idx] === 1'b1 && w < 300) begin
        @(posedge core_clk);
        #1;
        w++;
      end
      chk(what, wid, w);
    end
    @(posedge core_clk);
  endtask

  task pix(input vscc_pkg::vscc_pix_t p, input int dly);
    @(posedge core_clk);
    pix_valid <= 1'b1;
    pix_in <= p;
    meas("strobe_delay", 0, dly, 1);
    chk("pix_out", p, seen);
    chk("captured", p, cap_pix);
  endtask

  initial begin
    {rst, cfg_wr, hsync_in, vsync_in, clamp_in, coast_in, green_in, pix_valid} = 8'h80;
    pix_in = '0;
    cfg = vscc_pkg::CFG_RST;
    cfg_in = cfg;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk("sog_threshold", 6'h0f, sog_threshold);
    chk("pll_track", 1'b1, pll_track);
    pix(24'ha1b2c3, 3);
    cfg.phase = 5'h05;
    wr;
    pix(24'h5a0ff1, 8);
    chk("cap_cnt", 8'h02, cap_cnt);
    cfg.hs_pol = 1'b1;
    cfg.hso_width = 8'h04;
    wr;
    @(posedge core_clk);
    hsync_in <= 1'b1;
    meas("line_sync", 4, 11, 4);
    @(posedge core_clk);
    hsync_in <= 1'b0;
    meas("trailing_ref", 1, 0, 0);
    repeat (40) @(posedge core_clk);
    hsync_in <= 1'b1;
    meas("rise_ref", 1, 3, 1);
    cfg.hs_pol = 1'b0;
    wr;
    @(posedge core_clk);
    hsync_in <= 1'b0;
    meas("fall_ref", 1, 3, 1);
    cfg.clamp_place = 8'h03;
    cfg.clamp_dur = 8'h05;
    wr;
    @(posedge core_clk);
    clamp_in <= 1'b1;
    hsync_in <= 1'b1;
    meas("int_clamp", 2, 7, 5);
    cfg.ext_clamp = 1'b1;
    cfg.clamp_pol = 1'b1;
    clamp_in <= 1'b0;
    wr;
    clamp_in <= 1'b1;
    meas("ext_clamp_hi", 2, 3, 0);
    cfg.clamp_pol = 1'b0;
    wr;
    clamp_in <= 1'b0;
    meas("ext_clamp_lo", 2, 3, 0);
    cfg.ext_clamp = 1'b0;
    wr;
    green_in <= 1'b1;
    meas("slicer", 3, 3, 0);
    green_in <= 1'b0;
    hsync_in <= 1'b0;
    cfg.sog_sel = 1'b1;
    wr;
    hsync_in <= 1'b1;
    meas("raw_sync", 3, 3, 0);
    coast_in <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    chk("coast_track", 1'b0, pll_track);
    @(posedge core_clk);
    hsync_in <= 1'b0;
    meas("coast_ref", 1, 0, 0);
    cfg.coast_pol = 1'b0;
    wr;
    #1;
    chk("coast_pol0", 1'b1, pll_track);
    @(posedge core_clk);
    coast_in <= 1'b0;
    vsync_in <= 1'b1;
    meas("frame_sync", 5, 10, 0);
    cfg.vso_pol = 1'b0;
    wr;
    vsync_in <= 1'b0;
    meas("frame_inv", 5, 10, 0);
    cfg.hso_pol = 1'b0;
    cfg.hs_pol = 1'b1;
    hsync_in <= 1'b0;
    wr;
    hsync_in <= 1'b1;
    meas("line_inv", 6, 11, 4);
    pix(24'h3c4d5e, 8);
    chk("cap_hs", 1'b1, cap_hs);
    cfg.sog_level = 6'h00;
    wr;
    chk("sog_low", 6'h01, sog_threshold);
    cfg.sog_level = 6'h3f;
    wr;
    chk("sog_high", 6'h21, sog_threshold);
    cfg.sog_level = 6'h05;
    wr;
    chk("sog_mid", 6'h05, sog_threshold);
    give_verdict;
  end
endmodule
`default_nettype wire
